// ---- src/lces_pkg.sv ----
// Package holding constants and types for the lane code error status block.
package lces_pkg;

    localparam int LCES_LANES = 8;
    localparam int LCES_CNT_W = 8;
    localparam int LCES_ADDR_W = 12;
    localparam int LCES_DATA_W = 8;

    // Register offsets on the configuration port.
    localparam logic [LCES_ADDR_W-1:0] LCES_CODE_MISS_OFS = 12'h046E;
    localparam logic [LCES_ADDR_W-1:0] LCES_STRAY_CTRL_OFS = 12'h046F;

    // Reset values, counter ceiling and unmapped read data.
    localparam logic [LCES_DATA_W-1:0] LCES_STATUS_RST = 8'h00;
    localparam logic [LCES_CNT_W-1:0] LCES_CNT_RST = 8'h00;
    localparam logic [LCES_CNT_W-1:0] LCES_CNT_MAX = 8'hFF;
    localparam logic [LCES_DATA_W-1:0] LCES_UNMAPPED_DATA = 8'h00;

    // One register access request from the configuration port engine.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [LCES_ADDR_W-1:0] addr;
        logic [LCES_DATA_W-1:0] wdata;
    } lces_reg_req_type;

    // Per-lane error events from the lane decoders.
    typedef struct packed {
        logic [LCES_LANES-1:0] code_miss;
        logic [LCES_LANES-1:0] stray_ctrl;
    } lces_lane_evt_type;

endpackage

// ---- src/lces_err_counter.sv ----
// Saturating per-lane error counter with threshold compare.
module lces_err_counter #(
    parameter int CNT_W = 8
) (
    clk,
    rst_b,
    clear,
    incr,
    threshold,
    count,
    at_threshold
);
    import lces_pkg::*;

    input wire logic clk;
    input wire logic rst_b;
    input wire logic clear;
    input wire logic incr;
    input wire logic [CNT_W-1:0] threshold;
    output logic [CNT_W-1:0] count;
    output logic at_threshold;

    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;

    ////////////////////////////////////////////////////////////////////////////
    // Count saturates so a burst of errors never wraps back below threshold.
    always_comb begin
        nxt_count = count_ff;
        if (clear) begin
            nxt_count = '0;
        end else if (incr && (count_ff != {CNT_W{1'b1}})) begin
            nxt_count = count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    assign count = count_ff;
    assign at_threshold = (count_ff >= threshold); // Equal counts as reached.

endmodule

// ---- src/lces_top.sv ----
// Lane code error status registers with per-lane error counters.
//
// Summary of operation
// - Code miss flags per lane at 0x46E.
// - Code miss flag set when count reaches threshold.
// - Stray control flags per lane at 0x46F.
// - Stray control flag set when count reaches threshold.
// - Flags read-only, reset to zero.
//
// Each lane keeps two saturating counters, one per error kind. A status bit is
// the registered result of comparing its counter with the shared threshold, so
// it follows the counter one cycle late and falls when the counters are cleared under a nonzero threshold.
// Both status registers are read-only on the configuration port; a write to
// either offset is accepted and has no effect.
module lces_top (
    clk,
    rst_b,
    reg_req,
    lane_evt,
    error_count_threshold,
    counter_clear,
    reg_rdata,
    reg_rvalid,
    code_miss_status,
    stray_ctrl_status
);
    import lces_pkg::*;

    input wire logic clk;
    input wire logic rst_b;
    input wire lces_pkg::lces_reg_req_type reg_req;
    input wire lces_pkg::lces_lane_evt_type lane_evt;
    input wire logic [lces_pkg::LCES_CNT_W-1:0] error_count_threshold;
    input wire logic counter_clear;
    output logic [lces_pkg::LCES_DATA_W-1:0] reg_rdata;
    output logic reg_rvalid;
    output logic [lces_pkg::LCES_LANES-1:0] code_miss_status;
    output logic [lces_pkg::LCES_LANES-1:0] stray_ctrl_status;

    // Threshold compare results from the counter banks, one bit per lane.
    logic [LCES_LANES-1:0] code_miss_hit;
    logic [LCES_LANES-1:0] stray_ctrl_hit;

    // Event vectors taken out of the carrier, one bank of counters for each kind.
    logic [LCES_LANES-1:0] code_miss_evt;
    logic [LCES_LANES-1:0] stray_ctrl_evt;

    // Status registers as the configuration port sees them.
    logic [LCES_DATA_W-1:0] lane_code_miss_status_ff;
    logic [LCES_DATA_W-1:0] nxt_lane_code_miss_status;
    logic [LCES_DATA_W-1:0] lane_stray_control_char_status_ff;
    logic [LCES_DATA_W-1:0] nxt_lane_stray_control_char_status;

    // Read port state.
    logic [LCES_DATA_W-1:0] reg_rdata_ff;
    logic [LCES_DATA_W-1:0] nxt_reg_rdata;
    logic reg_rvalid_ff;
    logic nxt_reg_rvalid;

    ////////////////////////////////////////////////////////////////////////////
    // True when a request offset selects the given register. All twelve bits are
    // compared, so no alias in the neighbouring status space ever answers here.
    function automatic logic addr_hit(
        input logic [LCES_ADDR_W-1:0] addr,
        input logic [LCES_ADDR_W-1:0] ofs
    );
        return (addr == ofs);
    endfunction

    // Pack per-lane compare bits into a status byte; bit n belongs to lane n.
    // More lanes than register bits would need a second status byte.
    function automatic logic [LCES_DATA_W-1:0] lane_pack(
        input logic [LCES_LANES-1:0] hits
    );
        logic [LCES_DATA_W-1:0] val;
        val = LCES_STATUS_RST;
        for (int lane = 0; lane < LCES_LANES; lane++) begin
            val[lane] = hits[lane];
        end
        return val;
    endfunction

    // Decode a register offset into its read value; unmapped reads return zero.
    function automatic logic [LCES_DATA_W-1:0] read_mux(
        input logic [LCES_ADDR_W-1:0] addr,
        input logic [LCES_DATA_W-1:0] miss_val,
        input logic [LCES_DATA_W-1:0] stray_val
    );
        logic [LCES_DATA_W-1:0] val;
        val = LCES_UNMAPPED_DATA;
        if (addr_hit(addr, LCES_CODE_MISS_OFS)) begin
            val = miss_val;
        end else if (addr_hit(addr, LCES_STRAY_CTRL_OFS)) begin
            val = stray_val;
        end
        return val;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Split the lane events by kind. The decoders run on this same clock, so the
    // events need no synchroniser; a decoder on its own clock would need one.
    // Several lanes may report in one cycle; each bit is counted on its own.
    always_comb begin
        code_miss_evt = lane_evt.code_miss;
        stray_ctrl_evt = lane_evt.stray_ctrl;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One counter pair per lane; the two error kinds never share a count.
    // Counters saturate rather than wrap, so a long burst of errors cannot bring
    // a lane back below threshold. The count itself is not readable.
    for (genvar lane = 0; lane < LCES_LANES; lane++) begin : g_lane
        lces_err_counter #(
            .CNT_W(LCES_CNT_W)
        ) u_code_miss_cnt (
            .clk(clk),
            .rst_b(rst_b),
            .clear(counter_clear),
            .incr(code_miss_evt[lane]),
            .threshold(error_count_threshold),
            .count(),
            .at_threshold(code_miss_hit[lane])
        );

        lces_err_counter #(
            .CNT_W(LCES_CNT_W)
        ) u_stray_ctrl_cnt (
            .clk(clk),
            .rst_b(rst_b),
            .clear(counter_clear),
            .incr(stray_ctrl_evt[lane]),
            .threshold(error_count_threshold),
            .count(),
            .at_threshold(stray_ctrl_hit[lane])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next status values. The flags are live compares, not sticky bits: a flag
    // drops again once the counters are cleared under a nonzero threshold or the threshold is raised past the count.
    // code miss compare.
    always_comb begin
        nxt_lane_code_miss_status = lane_pack(code_miss_hit);
    end

    always_comb begin
        nxt_lane_stray_control_char_status = lane_pack(stray_ctrl_hit);
    end

    // The compare is registered once more so the status outputs come from flops;
    // this costs one cycle between the counting edge and the visible flag.
    // code miss register.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lane_code_miss_status_ff <= LCES_STATUS_RST;
        end else begin
            lane_code_miss_status_ff <= nxt_lane_code_miss_status;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lane_stray_control_char_status_ff <= LCES_STATUS_RST;
        end else begin
            lane_stray_control_char_status_ff <= nxt_lane_stray_control_char_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path. The offset is sampled on the edge that sees the read strobe, and
    // the data then holds until the next read so a slow port engine can fetch it.
    // Reads may come back to back, one per cycle.
    // code miss offset.
    always_comb begin
        nxt_reg_rdata = reg_rdata_ff;
        if (reg_req.rd) begin
            nxt_reg_rdata = read_mux(reg_req.addr, lane_code_miss_status_ff,
                                     lane_stray_control_char_status_ff);
        end
    end

    // Every read is answered, mapped or not, one cycle after its strobe.
    // Unmapped offsets return zero rather than stalling the port engine.
    always_comb begin
        nxt_reg_rvalid = reg_req.rd;
    end

    // Writes are accepted and dropped, since both registers are status only; this
    // keeps the port engine free of a per-address error. The write strobe and the
    // write data are therefore left unread on purpose.
    // writes ignored.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_ff <= LCES_STATUS_RST;
        end else begin
            reg_rdata_ff <= nxt_reg_rdata;
        end
    end

    // Read valid strobe; low in reset so no answer appears before a request.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= nxt_reg_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Every output is a register copy; nothing combinational reaches a port.
    assign reg_rdata = reg_rdata_ff;
    assign reg_rvalid = reg_rvalid_ff;
    assign code_miss_status = lane_code_miss_status_ff;
    assign stray_ctrl_status = lane_stray_control_char_status_ff;

endmodule

// ---- tb/lces_checker.sv ----
// Checker for the status flags and read port of the lane error block.
module lces_checker import lces_pkg::*; (
    input wire logic clk,
    input wire logic rst_b,
    input wire lces_reg_req_type reg_req,
    input wire lces_lane_evt_type lane_evt,
    input wire logic [7:0] error_count_threshold,
    input wire logic counter_clear,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [7:0] code_miss_status,
    input wire logic [7:0] stray_ctrl_status
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_miss_read_data: assert property (reg_req.rd && reg_req.addr == LCES_CODE_MISS_OFS
        |=> reg_rvalid && reg_rdata == $past(code_miss_status)) else $error("miss read bad");
    a_stray_read_data: assert property (reg_req.rd && reg_req.addr == LCES_STRAY_CTRL_OFS
        |=> reg_rvalid && reg_rdata == $past(stray_ctrl_status)) else $error("stray read bad");
    // While the threshold holds still, a flag may only rise two edges after an event on its own lane.
    a_miss_rise_cause: assert property ($past(rst_b, 3)
        && $past(error_count_threshold) == $past(error_count_threshold, 2)
        |-> (code_miss_status & ~$past(code_miss_status) & ~$past(lane_evt.code_miss, 2)) == 0)
        else $error("miss flag rose without event");
    a_stray_rise_cause: assert property ($past(rst_b, 3)
        && $past(error_count_threshold) == $past(error_count_threshold, 2)
        |-> (stray_ctrl_status & ~$past(stray_ctrl_status) & ~$past(lane_evt.stray_ctrl, 2)) == 0)
        else $error("stray flag rose without event");
    a_miss_no_fall: assert property ((~code_miss_status & $past(code_miss_status)) != 0
        |-> $past(counter_clear, 2) || $past(error_count_threshold) > $past(error_count_threshold, 2))
        else $error("miss flag fell without cause");
    a_clear_zeroes_all: assert property ($past(counter_clear) && $past(counter_clear, 2)
        && $past(error_count_threshold) != 0 |-> code_miss_status == 0 && stray_ctrl_status == 0)
        else $error("flags not cleared");
    c_read: cover property (reg_rvalid);
    c_miss_set: cover property (code_miss_status != 0);
    c_clear: cover property (counter_clear);
endmodule
bind lces_top lces_checker u_chk (
    .clk(clk),
    .rst_b(rst_b),
    .reg_req(reg_req),
    .lane_evt(lane_evt),
    .error_count_threshold(error_count_threshold),
    .counter_clear(counter_clear),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .code_miss_status(code_miss_status),
    .stray_ctrl_status(stray_ctrl_status)
);

// ---- tb/lces_lane_model.sv ----
// Lane transmitter model that raises per-lane error events.
module lces_lane_model import lces_pkg::*; (
    input wire logic clk,
    output lces_lane_evt_type lane_evt
);
    timeunit 1ns;
    timeprecision 1ns;
    // Events change on the falling edge so they are settled at the sampling edge.
    task automatic send(input logic [7:0] miss, input logic [7:0] stray, input int n);
        repeat (n) @(negedge clk) lane_evt = {miss, stray};
        @(negedge clk) lane_evt = '0;
    endtask
    initial lane_evt = '0;
endmodule

// ---- tb/lane_code_error_status_tb.sv ----
// Testbench for the lane code error status registers.
module lane_code_error_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import lces_pkg::*;
    logic clk = 0, rst_b = 0, counter_clear = 0, reg_rvalid;
    logic [7:0] error_count_threshold = 8'h03, reg_rdata, code_miss_status, stray_ctrl_status;
    lces_reg_req_type reg_req = '0;
    lces_lane_evt_type lane_evt;
    int fail_count = 0, n_compared = 0;
    always #20 clk = ~clk;
    lces_lane_model tx (.clk(clk), .lane_evt(lane_evt));
    lces_top dut (
        .clk(clk),
        .rst_b(rst_b),
        .reg_req(reg_req),
        .lane_evt(lane_evt),
        .error_count_threshold(error_count_threshold),
        .counter_clear(counter_clear),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .code_miss_status(code_miss_status),
        .stray_ctrl_status(stray_ctrl_status)
    );
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Requests are held for one cycle; the answer is checked one edge later.
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(negedge clk) reg_req = {1'b1, 1'b0, a, 8'h00};
        @(negedge clk) reg_req.rd = 1'b0;
        chk("rvalid", 8'h01, {7'h00, reg_rvalid});
        chk("rdata", exp, reg_rdata);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk) reg_req = {1'b0, 1'b1, a, d};
        @(negedge clk) reg_req.wr = 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Watchdog: the sequence needs well under a thousand cycles.
    initial begin
        #200us;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(negedge clk);
        chk("miss reset", 8'h00, code_miss_status);
        chk("stray reset", 8'h00, stray_ctrl_status);
        rst_b = 1;
        rd(LCES_STRAY_CTRL_OFS, 8'h00);
        tx.send(8'h81, 8'h24, 2);
        tx.send(8'h81, 8'h00, 1);
        rd(LCES_CODE_MISS_OFS, 8'h81);
        rd(LCES_STRAY_CTRL_OFS, 8'h00);
        tx.send(8'h00, 8'h24, 1);
        rd(LCES_STRAY_CTRL_OFS, 8'h24);
        wr(LCES_CODE_MISS_OFS, 8'h7e);
        rd(LCES_CODE_MISS_OFS, 8'h81);
        rd(12'h0470, LCES_UNMAPPED_DATA);
        error_count_threshold = 8'h00;
        rd(LCES_CODE_MISS_OFS, 8'hff);
        error_count_threshold = 8'h03;
        counter_clear = 1;
        repeat (2) @(negedge clk);
        counter_clear = 0;
        rd(LCES_STRAY_CTRL_OFS, 8'h00);
        error_count_threshold = 8'h00;
        @(negedge clk);
        chk("miss all", 8'hff, code_miss_status);
        rst_b = 0;
        @(negedge clk);
        chk("miss mid reset", 8'h00, code_miss_status);
        chk("stray mid reset", 8'h00, stray_ctrl_status);
        rst_b = 1;
        error_count_threshold = 8'h03;
        rd(LCES_CODE_MISS_OFS, 8'h00);
        tally_and_finish();
    end
endmodule
